/* design/query_err_pkg.sv */
/*
 * Constants for the query error register bank: register offsets, error codes,
 * reset values and field widths.
 * Assumes the including modules import the whole package.
 */
package query_err_pkg;
	localparam int                  DATA_W          = 16;
	localparam int                  ADDR_W          = 16;
	localparam int                  FUNC_W          = 8;
	localparam int                  CODE_W          = 8;
	localparam int                  DIAG_REGS       = 6;
	localparam int                  IDX_W           = 3;
	// Register offsets
	localparam logic [ADDR_W-1:0]   OFS_AREA_RESET  = 16'h005A;
	localparam logic [ADDR_W-1:0]   OFS_FAIL_FUNC   = 16'h005B;
	localparam logic [ADDR_W-1:0]   OFS_ERR_CODE    = 16'h005C;
	localparam logic [ADDR_W-1:0]   OFS_FAIL_ADDR   = 16'h005D;
	localparam logic [ADDR_W-1:0]   OFS_GOOD_WRITE  = 16'h005E;
	localparam logic [ADDR_W-1:0]   OFS_GOOD_READ   = 16'h005F;
	// Storage indices inside the small memory
	localparam logic [IDX_W-1:0]    IDX_AREA_RESET  = 3'h0;
	localparam logic [IDX_W-1:0]    IDX_FAIL_FUNC   = 3'h1;
	localparam logic [IDX_W-1:0]    IDX_ERR_CODE    = 3'h2;
	localparam logic [IDX_W-1:0]    IDX_FAIL_ADDR   = 3'h3;
	localparam logic [IDX_W-1:0]    IDX_GOOD_WRITE  = 3'h4;
	localparam logic [IDX_W-1:0]    IDX_GOOD_READ   = 3'h5;
	// Modbus exception that triggers capture
	localparam logic [CODE_W-1:0]   EXC_DEVICE_FAIL = 8'h04;
	// Detailed internal error codes
	localparam logic [CODE_W-1:0]   ERR_NONE        = 8'h00;
	localparam logic [CODE_W-1:0]   ERR_LIMIT       = 8'h02;
	localparam logic [CODE_W-1:0]   ERR_SUBINDEX    = 8'h03;
	localparam logic [CODE_W-1:0]   ERR_DATA_TYPE   = 8'h05;
	localparam logic [CODE_W-1:0]   ERR_DRIVE_COMM  = 8'h65;
	localparam logic [CODE_W-1:0]   ERR_TIMEOUT     = 8'h66;
	localparam logic [CODE_W-1:0]   ERR_READ_ONLY   = 8'h70;
	localparam logic [CODE_W-1:0]   ERR_GROUP_END   = 8'h71;
	localparam logic [CODE_W-1:0]   ERR_HIGH_NZ     = 8'h72;
	localparam logic [CODE_W-1:0]   ERR_LOW_ONLY    = 8'h73;
	localparam logic [CODE_W-1:0]   ERR_HIGH_ONLY   = 8'h74;
	// Value written to the reset register that clears the area
	localparam logic [DATA_W-1:0]   RESET_CMD       = 16'h0001;
	localparam logic [DATA_W-1:0]   REG_RESET_VAL   = 16'h0000;
	// Fault cause vector, one bit per detected cause; several may be set, lowest set bit wins
	localparam int                  CAUSE_N         = 10;
	localparam int                  C_LIMIT         = 0;
	localparam int                  C_SUBINDEX      = 1;
	localparam int                  C_DATA_TYPE     = 2;
	localparam int                  C_DRIVE_COMM    = 3;
	localparam int                  C_TIMEOUT       = 4;
	localparam int                  C_READ_ONLY     = 5;
	localparam int                  C_GROUP_END     = 6;
	localparam int                  C_HIGH_NZ       = 7;
	localparam int                  C_LOW_ONLY      = 8;
	localparam int                  C_HIGH_ONLY     = 9;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_CLEAR = 3'b010,
		ST_FILL  = 3'b100
	} upd_state_e;
endpackage

/* design/diag_regfile.sv */
/*
 * Small storage for the six diagnostic words, one write port and one read port.
 * Read data come out of a register one cycle after the read index.
 * Assumes a single clock and an asynchronous active low reset.
 */
module diag_regfile
	import query_err_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = DIAG_REGS
) (
	input  wire logic               mclk,
	input  wire logic               rst_n,
	input  wire logic               clr,
	input  wire logic               wr_en,
	input  wire logic [IDX_W-1:0]   wr_idx,
	input  wire logic [WIDTH-1:0]   wr_data,
	input  wire logic [IDX_W-1:0]   rd_idx,
	output logic      [WIDTH-1:0]   rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];

	// One storage word per entry; a clear zeroes at once every entry not written in the same cycle
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_word
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					mem_q[g] <= '0;
				end else if (wr_en && (wr_idx == IDX_W'(g))) begin
					mem_q[g] <= wr_data; // Write beats clear on the same word
				end else if (clr) begin
					mem_q[g] <= '0;
				end
			end
		end
	endgenerate

	// Registered read; out-of-range index reads as zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (int'(rd_idx) < DEPTH) begin
			rd_data <= mem_q[rd_idx];
		end else begin
			rd_data <= '0;
		end
	end
endmodule

/* design/modbus_query_error_registers.sv */
/*
 * Diagnostic register bank that records why the last Modbus query failed.
 * The query engine reports each finished query with a one-cycle done pulse,
 * its outcome and the detected fault causes; the client reaches the six
 * holding registers through the register access port of the query engine.
 * Assumes inputs are synchronous to mclk and reports arrive one at a time.
 */
// How it works
// - Exception 0x04 loads the error area
// - Each failure overwrites the earlier details
// - Successful query clears the error area
// - Writing 1 to reset register clears area
// - Failed function, error code, failed register
// - Holds last successfully written register address; a good write that meets a fill is dropped
// - Holds last successfully read register address; a good read that meets a fill or a good write is dropped
// - Success reports code 0x00
// - Value outside limits reports 0x02
// - Missing array subindex reports 0x03
// - Wrong data type reports 0x05
// - Unclassified drive communication failure reports 0x65
// - Drive communication timeout reports 0x66
// - Non-zero write to read-only reports 0x70
// - Write across parameter groups reports 0x71
// - Non-zero upper bytes via 32-bit reports 0x72
// - Only low half of 32-bit reports 0x73
// - Only high half of 32-bit reports 0x74
module modbus_query_error_registers
	import query_err_pkg::*;
(
	input  wire logic                mclk,
	input  wire logic                rst_n,
	// Query outcome report from the query engine
	input  wire logic                query_done,
	input  wire logic                query_ok,
	input  wire logic [CODE_W-1:0]   query_exception,
	input  wire logic [FUNC_W-1:0]   query_function,
	input  wire logic [ADDR_W-1:0]   query_fail_addr,
	input  wire logic [CAUSE_N-1:0]  query_cause,
	// Successful single register transfers
	input  wire logic                good_write,
	input  wire logic [ADDR_W-1:0]   good_write_addr,
	input  wire logic                good_read,
	input  wire logic [ADDR_W-1:0]   good_read_addr,
	// Holding register access
	input  wire logic                reg_rd,
	input  wire logic                reg_wr,
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	output logic      [DATA_W-1:0]   reg_rdata,
	output logic                     reg_rvalid,
	output logic                     reg_hit,
	output logic      [CODE_W-1:0]   error_code
);
	upd_state_e            state_q;
	upd_state_e            state_d;
	logic [CODE_W-1:0]     code_q;
	logic [CODE_W-1:0]     code_sel;
	logic [FUNC_W-1:0]     func_q;
	logic [ADDR_W-1:0]     fail_addr_q;
	logic                  fill_step_q;
	logic                  area_clear;
	logic                  wr_en;
	logic [IDX_W-1:0]      wr_idx;
	logic [DATA_W-1:0]     wr_data;
	logic [IDX_W-1:0]      rd_idx;
	logic                  rd_pend_q;
	logic                  hit_now;
	logic [DATA_W-1:0]     mem_rdata;
	logic                  capture;
	logic                  reset_req;
	logic                  fill_wr;
	logic [IDX_W-1:0]      fill_idx;
	logic [DATA_W-1:0]     fill_data;
	logic [CAUSE_N-1:0]    first_cause;

	// A failure is recorded only for the generic device-failure exception
	assign capture   = query_done && !query_ok && (query_exception == EXC_DEVICE_FAIL);
	assign reset_req = reg_wr && (reg_addr == OFS_AREA_RESET) && (reg_wdata == RESET_CMD);

	// Per cause bit: it survives only if no lower bit is set, so lowest wins
	genvar gc;
	generate
		for (gc = 0; gc < CAUSE_N; gc++) begin : g_cause
			if (gc == 0) begin : g_low
				assign first_cause[gc] = query_cause[gc];
			end else begin : g_up
				assign first_cause[gc] = query_cause[gc] && (query_cause[gc-1:0] == '0);
			end
		end
	endgenerate

	// Surviving bit to its code; no cause at all is a general drive fault
	always_comb begin
		code_sel = ERR_DRIVE_COMM;
		if (first_cause[C_LIMIT]) begin
			code_sel = ERR_LIMIT;
		end
		if (first_cause[C_SUBINDEX]) begin
			code_sel = ERR_SUBINDEX;
		end
		if (first_cause[C_DATA_TYPE]) begin
			code_sel = ERR_DATA_TYPE;
		end
		if (first_cause[C_DRIVE_COMM]) begin
			code_sel = ERR_DRIVE_COMM;
		end
		if (first_cause[C_TIMEOUT]) begin
			code_sel = ERR_TIMEOUT;
		end
		if (first_cause[C_READ_ONLY]) begin
			code_sel = ERR_READ_ONLY;
		end
		if (first_cause[C_GROUP_END]) begin
			code_sel = ERR_GROUP_END;
		end
		if (first_cause[C_HIGH_NZ]) begin
			code_sel = ERR_HIGH_NZ;
		end
		if (first_cause[C_LOW_ONLY]) begin
			code_sel = ERR_LOW_ONLY;
		end
		if (first_cause[C_HIGH_ONLY]) begin
			code_sel = ERR_HIGH_ONLY;
		end
	end

	// Next state: a fresh capture always wins over a pending clear
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (capture) begin
					state_d = ST_FILL;
				end else if ((query_done && query_ok) || reset_req) begin
					state_d = ST_CLEAR;
				end
			end
			ST_CLEAR: begin
				state_d = capture ? ST_FILL : ST_IDLE;
			end
			ST_FILL: begin
				if (capture) begin
					state_d = ST_FILL;
				end else if ((query_done && query_ok) || reset_req) begin
					state_d = ST_CLEAR;
				end else if (fill_step_q) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Latch the failure details for the fill; a new capture overwrites them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			code_q <= ERR_NONE;
		end else if (capture) begin
			code_q <= code_sel;
		end else if (area_clear) begin
			code_q <= ERR_NONE;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			func_q <= '0;
		end else if (capture) begin
			func_q <= query_function;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fail_addr_q <= '0;
		end else if (capture) begin
			fail_addr_q <= query_fail_addr;
		end
	end

	// Fill sequencing: one word per cycle, restarted by a fresh capture
	logic [1:0] fill_cnt_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fill_cnt_q <= 2'h0;
		end else if (state_q != ST_FILL || capture) begin
			fill_cnt_q <= 2'h0;
		end else begin
			fill_cnt_q <= fill_cnt_q + 2'h1;
		end
	end

	// Last-step flag, high while the final word is being written
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fill_step_q <= 1'b0;
		end else if (state_q != ST_FILL || capture) begin
			fill_step_q <= 1'b0;
		end else begin
			fill_step_q <= (fill_cnt_q == 2'h1);
		end
	end

	// Clear always runs so no stale last-good word survives a quick refill
	assign area_clear = (state_q == ST_CLEAR);
	assign fill_wr    = (state_q == ST_FILL) && !capture;

	// Word that the fill writes in this cycle, chosen by the step count
	always_comb begin
		fill_idx  = IDX_FAIL_ADDR;
		fill_data = fail_addr_q;
		unique case (fill_cnt_q)
			2'h0: begin
				fill_idx  = IDX_FAIL_FUNC;
				fill_data = DATA_W'(func_q);
			end
			2'h1: begin
				fill_idx  = IDX_ERR_CODE;
				fill_data = DATA_W'(code_q);
			end
			default: begin
				fill_idx  = IDX_FAIL_ADDR;
				fill_data = fail_addr_q;
			end
		endcase
	end

	// Single write port: a good transfer that meets a fill is dropped
	always_comb begin
		wr_en   = 1'b0;
		wr_idx  = IDX_AREA_RESET;
		wr_data = REG_RESET_VAL;
		if (fill_wr) begin
			wr_en   = 1'b1;
			wr_idx  = fill_idx;
			wr_data = fill_data;
		end else if (good_write) begin
			wr_en   = 1'b1;
			wr_idx  = IDX_GOOD_WRITE;
			wr_data = good_write_addr;
		end else if (good_read) begin
			wr_en   = 1'b1;
			wr_idx  = IDX_GOOD_READ;
			wr_data = good_read_addr;
		end
	end

	// The reset register holds no state: it always reads as zero
	always_comb begin
		hit_now = 1'b1;
		rd_idx  = IDX_AREA_RESET;
		unique case (reg_addr)
			OFS_AREA_RESET: rd_idx = IDX_AREA_RESET;
			OFS_FAIL_FUNC:  rd_idx = IDX_FAIL_FUNC;
			OFS_ERR_CODE:   rd_idx = IDX_ERR_CODE;
			OFS_FAIL_ADDR:  rd_idx = IDX_FAIL_ADDR;
			OFS_GOOD_WRITE: rd_idx = IDX_GOOD_WRITE;
			OFS_GOOD_READ:  rd_idx = IDX_GOOD_READ;
			default:        hit_now = 1'b0;
		endcase
	end

	diag_regfile #(
		.WIDTH (DATA_W),
		.DEPTH (DIAG_REGS)
	) u_store (
		.mclk    (mclk),
		.rst_n   (rst_n),
		.clr     (area_clear),
		.wr_en   (wr_en),
		.wr_idx  (wr_idx),
		.wr_data (wr_data),
		.rd_idx  (rd_idx),
		.rd_data (mem_rdata)
	);

	// Read pipeline: store answers after one cycle, bank adds one more stage
	logic hit_pend_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= reg_rd;
		end
	end

	// Hit flag travels beside the request through the same stage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hit_pend_q <= 1'b0;
		end else begin
			hit_pend_q <= reg_rd && hit_now;
		end
	end

	// Answer strobe, hit flag and data leave from flip-flops in one cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rd_pend_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_hit <= 1'b0;
		end else begin
			reg_hit <= hit_pend_q;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= hit_pend_q ? mem_rdata : '0; // Unmapped reads as zero
		end
	end

	// Live copy of the detailed code for the query engine and status lamps
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			error_code <= ERR_NONE;
		end else if (capture) begin
			error_code <= code_sel;
		end else if (query_done && query_ok) begin
			error_code <= ERR_NONE;
		end else if (reset_req) begin
			error_code <= ERR_NONE;
		end
	end
endmodule

/* dv/query_err_monitor.sv */
/*
 * Port assertions for the query error register bank.
 * Assumes it is bound to the bank top, one clock, async active low reset.
 */
module query_err_monitor
	import query_err_pkg::*;
(
	input wire logic                mclk,
	input wire logic                rst_n,
	input wire logic                query_done,
	input wire logic                query_ok,
	input wire logic [CODE_W-1:0]   query_exception,
	input wire logic [CAUSE_N-1:0]  query_cause,
	input wire logic                reg_rd,
	input wire logic [ADDR_W-1:0]   reg_addr,
	input wire logic [DATA_W-1:0]   reg_rdata,
	input wire logic                reg_rvalid,
	input wire logic                reg_hit,
	input wire logic                reg_wr,
	input wire logic [DATA_W-1:0]   reg_wdata,
	input wire logic [CODE_W-1:0]   error_code
);
	timeunit 1ns;
	timeprecision 1ns;
	logic mapped;

	// Cause bits to code, lowest set bit wins, none set is a general fault
	function automatic logic [CODE_W-1:0] code_of(input logic [CAUSE_N-1:0] c);
		logic [CODE_W-1:0] t [CAUSE_N];
		t = '{ERR_LIMIT, ERR_SUBINDEX, ERR_DATA_TYPE, ERR_DRIVE_COMM, ERR_TIMEOUT,
			ERR_READ_ONLY, ERR_GROUP_END, ERR_HIGH_NZ, ERR_LOW_ONLY, ERR_HIGH_ONLY};
		code_of = ERR_DRIVE_COMM;
		for (int i = CAUSE_N - 1; i >= 0; i--) if (c[i]) code_of = t[i];
	endfunction

	// Six words sit at consecutive offsets
	assign mapped = reg_addr >= OFS_AREA_RESET && reg_addr <= OFS_GOOD_READ;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_read_latency: assert property (reg_rd |-> ##2 reg_rvalid)
		else $error("read answer missing");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("read answer without request");
	a_hit_mapped: assert property (reg_rd && mapped |-> ##2 reg_hit)
		else $error("mapped read not hit");
	a_miss_zero: assert property (reg_rd && !mapped |-> ##2 !reg_hit && reg_rdata == 16'h0000)
		else $error("unmapped read answered");
	a_reset_reads_zero: assert property (reg_rd && reg_addr == OFS_AREA_RESET
		|-> ##2 reg_rdata == REG_RESET_VAL) else $error("reset word not zero");
	a_fail_code: assert property (query_done && !query_ok && query_exception == EXC_DEVICE_FAIL
		|=> error_code == code_of($past(query_cause))) else $error("wrong error code");
	a_ok_code: assert property (query_done && query_ok |=> error_code == ERR_NONE)
		else $error("success code not zero");
	a_refuse_other: assert property (query_done && !query_ok
		&& query_exception != EXC_DEVICE_FAIL |=> $stable(error_code)) else $error("code moved");
	a_code_holds: assert property (!query_done && !reg_wr |=> $stable(error_code))
		else $error("code moved without query");
	a_reset_clears: assert property (reg_wr && reg_addr == OFS_AREA_RESET
		&& reg_wdata == RESET_CMD && !query_done |=> error_code == ERR_NONE)
		else $error("reset write left code");
	a_other_write_keeps: assert property (reg_wr && reg_wdata != RESET_CMD
		&& !query_done |=> $stable(error_code)) else $error("ignored write moved code");
endmodule

bind modbus_query_error_registers query_err_monitor mon_u (.mclk, .rst_n, .query_done,
	.query_ok, .query_exception, .query_cause, .reg_rd, .reg_addr, .reg_rdata,
	.reg_rvalid, .reg_hit, .reg_wr, .reg_wdata, .error_code);

/* dv/modbus_client_model.sv */
/*
 * Client that reads and writes the holding registers of the bank.
 * Assumes the bench calls its tasks one at a time; drives at falling edges.
 */
module modbus_client_model
	import query_err_pkg::*;
(
	input  wire logic               mclk,
	output logic                    reg_rd,
	output logic                    reg_wr,
	output logic      [ADDR_W-1:0]  reg_addr,
	output logic      [DATA_W-1:0]  reg_wdata,
	input  wire logic [DATA_W-1:0]  reg_rdata,
	input  wire logic               reg_rvalid,
	input  wire logic               reg_hit
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus at time zero
	initial begin
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
	end

	// Released lines show the inverse so a stale value is never trusted
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
		output logic h);
		@(negedge mclk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge mclk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		// Answer stands between the next two rising edges, settled here
		@(negedge mclk);
		d = reg_rvalid ? reg_rdata : ~reg_rdata;
		h = reg_hit;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(negedge mclk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
endmodule

/* dv/modbus_query_error_registers_test.sv */
/*
 * Self-checking bench for the query error register bank.
 * Assumes the client model and the bound monitor; 25 MHz clock.
 */
module modbus_query_error_registers_test
	import query_err_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic                mclk, rst_n, query_done, query_ok, good_write, good_read;
	logic [CODE_W-1:0]   query_exception, error_code;
	logic [FUNC_W-1:0]   query_function;
	logic [ADDR_W-1:0]   query_fail_addr, good_write_addr, good_read_addr, reg_addr;
	logic [CAUSE_N-1:0]  query_cause;
	logic                reg_rd, reg_wr, reg_rvalid, reg_hit;
	logic [DATA_W-1:0]   reg_wdata, reg_rdata;
	logic [DATA_W-1:0]   e [6];
	int                  n_fail, total_checks;

	modbus_query_error_registers dut_u (
		.mclk            (mclk),
		.rst_n           (rst_n),
		.query_done      (query_done),
		.query_ok        (query_ok),
		.query_exception (query_exception),
		.query_function  (query_function),
		.query_fail_addr (query_fail_addr),
		.query_cause     (query_cause),
		.good_write      (good_write),
		.good_write_addr (good_write_addr),
		.good_read       (good_read),
		.good_read_addr  (good_read_addr),
		.reg_rd          (reg_rd),
		.reg_wr          (reg_wr),
		.reg_addr        (reg_addr),
		.reg_wdata       (reg_wdata),
		.reg_rdata       (reg_rdata),
		.reg_rvalid      (reg_rvalid),
		.reg_hit         (reg_hit),
		.error_code      (error_code)
	);
	modbus_client_model client_u (
		.mclk       (mclk),
		.reg_rd     (reg_rd),
		.reg_wr     (reg_wr),
		.reg_addr   (reg_addr),
		.reg_wdata  (reg_wdata),
		.reg_rdata  (reg_rdata),
		.reg_rvalid (reg_rvalid),
		.reg_hit    (reg_hit)
	);

	// Free running clock
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected code from the lowest set cause bit
	function automatic logic [CODE_W-1:0] exp_code(input logic [CAUSE_N-1:0] c);
		logic [CODE_W-1:0] t [CAUSE_N];
		t = '{8'h02, 8'h03, 8'h05, 8'h65, 8'h66, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74};
		exp_code = 8'h65;
		for (int i = CAUSE_N - 1; i >= 0; i--) if (c[i]) exp_code = t[i];
	endfunction

	// Read every word plus both neighbours outside the map
	task automatic check_all();
		logic [DATA_W-1:0] d;
		logic              h;
		for (int i = -1; i < 7; i++) begin
			client_u.rd(OFS_AREA_RESET + 16'(i), d, h);
			chk16(d, (i < 0 || i > 5) ? 16'h0000 : e[i]);
			chk16({15'h0000, h}, {15'h0000, i >= 0 && i <= 5});
		end
	endtask

	task automatic query(input logic ok, input logic [CODE_W-1:0] exc,
		input logic [CAUSE_N-1:0] c);
		@(negedge mclk);
		{query_done, query_ok, query_exception, query_cause} = {1'b1, ok, exc, c};
		query_function = FUNC_W'($urandom);
		query_fail_addr = ADDR_W'($urandom);
		if (ok) e = '{default: 16'h0000};
		else if (exc == EXC_DEVICE_FAIL) begin
			e[1] = {8'h00, query_function};
			e[2] = {8'h00, exp_code(c)};
			e[3] = query_fail_addr;
		end
		@(negedge mclk);
		query_done = 1'b0;
		repeat (6) @(negedge mclk);
		chk16({8'h00, error_code}, e[2]);
	endtask

	// Write pulse first, read pulse after, so neither is dropped
	task automatic good();
		@(negedge mclk);
		{good_write, good_write_addr} = {1'b1, ADDR_W'($urandom)};
		e[4] = good_write_addr;
		@(negedge mclk);
		good_write = 1'b0;
		{good_read, good_read_addr} = {1'b1, ADDR_W'($urandom)};
		e[5] = good_read_addr;
		@(negedge mclk);
		good_read = 1'b0;
	endtask

	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		#200us;
		n_fail++;
		report_and_stop();
	end

	initial begin
		{query_done, query_ok, good_write, good_read} = 4'h0;
		{query_exception, query_function, query_fail_addr, query_cause} = '0;
		{good_write_addr, good_read_addr} = '0;
		e = '{default: 16'h0000};
		void'($urandom(18574));
		rst_n = 1'b0;
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		check_all();
		good();
		check_all();
		for (int i = 0; i < CAUSE_N; i++) begin
			query(1'b0, EXC_DEVICE_FAIL, CAUSE_N'(1 << i));
			check_all();
		end
		query(1'b0, EXC_DEVICE_FAIL, 10'h000);
		query(1'b0, EXC_DEVICE_FAIL, 10'h330);
		query(1'b0, 8'h03, 10'h001);
		check_all();
		query(1'b1, 8'h00, 10'h000);
		check_all();
		query(1'b0, EXC_DEVICE_FAIL, 10'h002);
		good();
		client_u.wr(OFS_AREA_RESET, 16'h0000);
		client_u.wr(OFS_ERR_CODE, 16'h0001);
		check_all();
		client_u.wr(OFS_AREA_RESET, RESET_CMD);
		e = '{default: 16'h0000};
		repeat (3) @(negedge mclk);
		chk16({8'h00, error_code}, 16'h0000);
		check_all();
		for (int k = 0; k < 6; k++) begin
			good();
			query(1'($urandom), EXC_DEVICE_FAIL, CAUSE_N'($urandom));
			check_all();
		end
		report_and_stop();
	end
endmodule
